// ### sim/fbp_ctrl_assertions.sv
// port checker for the flash protection controller
`timescale 1ns/1ns
module fbp_ctrl_chk (
    // clock and reset
    input wire clk,
    input wire sys_rst,
    // axi4-lite write answer
    input wire [1:0] s_bresp_r,
    input wire s_bvalid_r,
    input wire s_bready,
    // flash pins
    input wire [23:0] fl_addr,
    input wire [15:0] fl_dq_o,
    input wire fl_dq_oe,
    input wire fl_ce_n,
    input wire fl_oe_n,
    input wire fl_we_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // strobe framing
    strobe_excl_a: assert property (fl_oe_n || fl_we_n)
        else $error("strobes overlap");
    read_release_a: assert property (!fl_oe_n |-> !fl_dq_oe)
        else $error("data driven during read");
    write_drive_a: assert property (!fl_we_n |-> fl_dq_oe && !fl_ce_n)
        else $error("write strobe without data");
    write_stable_a: assert property (!fl_we_n && $past(!fl_we_n) |->
        $stable(fl_addr) && $stable(fl_dq_o)) else $error("write payload moved");
    we_width_a: assert property ($fell(fl_we_n) |-> !fl_we_n [*4])
        else $error("write strobe short");
    ce_setup_a: assert property ($fell(fl_we_n) || $fell(fl_oe_n) |-> $past(!fl_ce_n, 2))
        else $error("chip select setup short");
    upper_zero_a: assert property ($fell(fl_we_n) && fl_dq_o[7:0] inside {8'hAA, 8'h55, 8'h90}
        |-> fl_dq_o[15:8] == 8'h00) else $error("upper byte not zero");
    bresp_hold_a: assert property (s_bvalid_r && !s_bready |=> s_bvalid_r && $stable(s_bresp_r))
        else $error("write answer dropped");
    // main traffic
    cover property ($fell(fl_we_n));
    cover property ($fell(fl_oe_n));
    cover property (s_bvalid_r && s_bready);
endmodule // fbp_ctrl_chk
bind fbp_ctrl fbp_ctrl_chk i_fbp_ctrl_chk (.clk(clk), .sys_rst(sys_rst), .s_bresp_r(s_bresp_r),
    .s_bvalid_r(s_bvalid_r), .s_bready(s_bready), .fl_addr(fl_addr), .fl_dq_o(fl_dq_o),
    .fl_dq_oe(fl_dq_oe), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n));

// ### sim/fbp_flash_model.sv
// behavioural x8 flash answering protection command sequences
`timescale 1ns/1ns
module fbp_flash_model #(
    parameter PWLOCK_BIT = 2 // arbitrary position of the password lock bit
) (
    // flash pins
    input wire [23:0] fl_addr,
    input wire [15:0] fl_dq_o,
    input wire fl_ce_n,
    input wire fl_oe_n,
    input wire fl_we_n,
    output wire [15:0] fl_dq_i
);
    reg [15:0] lreg_r = 16'hFFFF;
    reg [63:0] pw_r = {64{1'b1}};
    reg [63:0] cand_r;
    reg [15:0] nv_r = 16'hFFFF;
    reg [15:0] vol_r = 16'hFFFF;
    reg lbit_r = 1'b1;
    reg [2:0] mode_r = 3'h0;
    reg [3:0] step_r = 4'h0;
    reg [3:0] upc_r = 4'h0;
    reg [7:0] pend_r = 8'h00;
    reg [15:0] rd_r;
    reg [15:0] last_r = 16'h0000;
    wire [7:0] d = fl_dq_o[7:0];
    wire [3:0] blk = fl_addr[19:16];
    wire drv = !fl_ce_n && !fl_oe_n;
    // decode on the closing edge of each write strobe; no clock in the device
    always @(posedge fl_we_n) if (!fl_ce_n) begin
        if (mode_r == 3'h0) begin
            // a stray cycle drops a partial entry
            step_r <= (d == 8'hAA) ? 4'h1 : (step_r == 4'h1 && d == 8'h55) ? 4'h2 : 4'h0;
            if (step_r == 4'h2) case (d)
                8'h40: mode_r <= 3'h1;
                8'h60: mode_r <= 3'h2;
                8'hC0: mode_r <= 3'h3;
                8'h50: mode_r <= 3'h4;
                8'hE0: mode_r <= 3'h5;
                default: ;
            endcase
        end else if (upc_r != 4'h0) begin
            cand_r[fl_addr[2:0]*8 +: 8] <= d;
            upc_r <= ((upc_r == 4'h1 && d != 8'h03) || upc_r == 4'hA) ? 4'h0 : upc_r + 4'h1;
            if (upc_r == 4'hA && d == 8'h29 && cand_r == pw_r) lbit_r <= 1'b1;
        end else if (pend_r == 8'hA0) begin
            pend_r <= 8'h00;
            case (mode_r)
                3'h1: lreg_r <= lreg_r & fl_dq_o;
                3'h2: if (lreg_r[PWLOCK_BIT]) pw_r[fl_addr[2:0]*8 +: 8] <= d;
                3'h3: if (lbit_r && d == 8'h00) nv_r[blk] <= 1'b0;
                3'h4: if (d == 8'h00) lbit_r <= 1'b0;
                default: vol_r[blk] <= d[0];
            endcase
        end else if (pend_r == 8'h80) begin
            pend_r <= 8'h00;
            // preprogram folded into the erase, the end state is the same
            if (d == 8'h30 && lbit_r && mode_r == 3'h3) nv_r <= 16'hFFFF;
        end else if (pend_r == 8'h90) begin
            pend_r <= 8'h00;
            if (d == 8'h00) mode_r <= 3'h0;
        end else begin
            pend_r <= d;
            if (d == 8'h25 && mode_r == 3'h2) upc_r <= 4'h1;
        end
    end
    // read data by mode
    always @* begin
        case (mode_r)
            3'h1: rd_r = lreg_r;
            3'h2: rd_r = lreg_r[PWLOCK_BIT] ? {8'h00, pw_r[fl_addr[2:0]*8 +: 8]} : 16'h0;
            3'h3: rd_r = {15'h0, nv_r[blk]};
            3'h4: rd_r = {15'h0, lbit_r};
            3'h5: rd_r = {15'h0, vol_r[blk]};
            default: rd_r = {8'hA5, fl_addr[7:0]};
        endcase
        if (drv) last_r = rd_r;
    end
    // released bus shows the inverse, so a stale sample cannot pass
    assign fl_dq_i = drv ? rd_r : ~last_r;
endmodule // fbp_flash_model

// ### sim/test_fbp_ctrl.sv
// self-checking bench for the flash protection controller
`timescale 1ns/1ns
module test_fbp_ctrl;
    logic clk = 1'b0, sys_rst = 1'b1;
    logic [11:0] aw = 12'h0, ar = 12'h0;
    logic [31:0] wd = 32'h0;
    logic awv = 1'b0, wv = 1'b0, bq = 1'b0, arv = 1'b0, rq = 1'b0;
    wire awr, wr, bv, arr, rv, fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n;
    wire [1:0] br, rr;
    wire [31:0] rdat;
    wire [23:0] fl_addr;
    wire [15:0] fl_dq_o, fl_dq_i;
    integer error_cnt = 0, checked = 0;
    fbp_ctrl #(.UNLOCK_GAP_CYC(2000), .PHASE_CYC(3)) i_fbp_ctrl (.clk(clk), .sys_rst(sys_rst),
        .s_awaddr(aw), .s_awvalid(awv), .s_awready_r(awr), .s_wdata(wd), .s_wstrb(4'hF),
        .s_wvalid(wv), .s_wready_r(wr), .s_bresp_r(br), .s_bvalid_r(bv), .s_bready(bq),
        .s_araddr(ar), .s_arvalid(arv), .s_arready_r(arr), .s_rdata_r(rdat), .s_rresp_r(rr),
        .s_rvalid_r(rv), .s_rready(rq), .fl_addr(fl_addr), .fl_dq_o(fl_dq_o),
        .fl_dq_oe(fl_dq_oe), .fl_dq_i(fl_dq_i), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
        .fl_we_n(fl_we_n));
    fbp_flash_model i_fbp_flash_model (.fl_addr(fl_addr), .fl_dq_o(fl_dq_o), .fl_ce_n(fl_ce_n),
        .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .fl_dq_i(fl_dq_i));
    always #5 clk = ~clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked = checked + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checked=%0d error_cnt=%0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // address and data offered together, each released when taken
    task automatic axw(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        aw <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bq <= 1'b1;
        fork
            begin do @(posedge clk); while (!awr); awv <= 1'b0; end
            begin do @(posedge clk); while (!wr); wv <= 1'b0; end
        join
        while (!bv) @(posedge clk);
        bq <= 1'b0;
    endtask
    task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        ar <= a;
        arv <= 1'b1;
        rq <= 1'b1;
        do @(posedge clk); while (!arr);
        arv <= 1'b0;
        while (!rv) @(posedge clk);
        d = rdat;
        r = rr;
        rq <= 1'b0;
    endtask
    // one operation: refusal flag and, for reads, the low data half are judged
    task automatic run(input logic [3:0] c, input logic [23:0] a, input logic [15:0] w,
        input logic rf, input logic [15:0] re);
        logic [31:0] st, rd;
        logic [1:0] r;
        axw(12'h004, {8'h00, a});
        axw(12'h008, {16'h0, w});
        axw(12'h000, {1'b1, 27'h0, c});
        st = 32'h0;
        while (st[2:1] === 2'b00) axr(12'h00C, st, r);
        axw(12'h00C, 32'h00000006);
        axr(12'h010, rd, r);
        chk({31'h0, st[2]}, {31'h0, rf});
        if (c == 4'h7) chk({16'h0, rd[15:0]}, {16'h0, re});
    endtask
    task automatic t_regs;
        logic [31:0] d;
        logic [1:0] r;
        axr(12'h00C, d, r);
        chk(d, 32'h0);
        axr(12'h014, d, r);
        chk(d, 32'hFFFFFFFF);
        axr(12'h020, d, r);
        chk({r, d[29:0]}, 32'h80000000);
        axw(12'h020, 32'h0);
        chk({30'h0, br}, 32'h2);
    endtask
    task automatic t_password;
        run(4'h1, 24'h0, 16'h0, 1'b0, 16'h0);
        run(4'h6, 24'h000003, 16'h005A, 1'b0, 16'h0);
        run(4'h7, 24'h000003, 16'h0, 1'b0, 16'h005A);
        run(4'h7, 24'h000004, 16'h0, 1'b0, 16'h00FF);
        run(4'h5, 24'h0, 16'h0, 1'b0, 16'h0);
        run(4'h7, 24'h000003, 16'h0, 1'b0, 16'hA503);
    endtask
    task automatic t_nv_lock;
        run(4'h2, 24'h0, 16'h0, 1'b0, 16'h0);
        run(4'h6, 24'h020000, 16'h0000, 1'b0, 16'h0);
        run(4'h7, 24'h021234, 16'h0, 1'b0, 16'h0000);
        run(4'h7, 24'h030000, 16'h0, 1'b0, 16'h0001);
        run(4'h5, 24'h0, 16'h0, 1'b0, 16'h0);
        run(4'h3, 24'h0, 16'h0, 1'b0, 16'h0);
        run(4'h7, 24'h000000, 16'h0, 1'b0, 16'h0001);
        run(4'h6, 24'h0, 16'h0000, 1'b0, 16'h0);
        run(4'h7, 24'h000000, 16'h0, 1'b0, 16'h0000);
        run(4'h5, 24'h0, 16'h0, 1'b0, 16'h0);
        run(4'h2, 24'h0, 16'h0, 1'b0, 16'h0);
        run(4'h8, 24'h0, 16'h0, 1'b0, 16'h0);
        run(4'h7, 24'h020000, 16'h0, 1'b0, 16'h0000);
        run(4'h5, 24'h0, 16'h0, 1'b0, 16'h0);
    endtask
    task automatic t_unlock;
        axw(12'h014, 32'h5AFFFFFF);
        axw(12'h018, 32'hFFFFFFFF);
        run(4'h1, 24'h0, 16'h0, 1'b0, 16'h0);
        run(4'h9, 24'h0, 16'h0, 1'b0, 16'h0);
        run(4'h9, 24'h0, 16'h0, 1'b1, 16'h0);
        run(4'h5, 24'h0, 16'h0, 1'b0, 16'h0);
        run(4'h3, 24'h0, 16'h0, 1'b0, 16'h0);
        run(4'h7, 24'h000000, 16'h0, 1'b0, 16'h0001);
        run(4'h5, 24'h0, 16'h0, 1'b0, 16'h0);
        run(4'h2, 24'h0, 16'h0, 1'b0, 16'h0);
        run(4'h8, 24'h0, 16'h0, 1'b0, 16'h0);
        run(4'h7, 24'h020000, 16'h0, 1'b0, 16'h0001);
        run(4'h5, 24'h0, 16'h0, 1'b0, 16'h0);
    endtask
    task automatic t_vol_lreg;
        run(4'h4, 24'h0, 16'h0, 1'b0, 16'h0);
        run(4'h6, 24'h050000, 16'h0000, 1'b0, 16'h0);
        run(4'h7, 24'h050000, 16'h0, 1'b0, 16'h0000);
        run(4'h6, 24'h050000, 16'h0001, 1'b0, 16'h0);
        run(4'h7, 24'h050000, 16'h0, 1'b0, 16'h0001);
        run(4'h5, 24'h0, 16'h0, 1'b0, 16'h0);
        run(4'h0, 24'h0, 16'h0, 1'b0, 16'h0);
        run(4'h6, 24'h0, 16'hFFFB, 1'b0, 16'h0);
        run(4'h7, 24'h0, 16'h0, 1'b0, 16'hFFFB);
        run(4'h5, 24'h0, 16'h0, 1'b0, 16'h0);
        run(4'h1, 24'h0, 16'h0, 1'b0, 16'h0);
        run(4'h7, 24'h000003, 16'h0, 1'b0, 16'h0000);
        run(4'h5, 24'h0, 16'h0, 1'b0, 16'h0);
    endtask
    // main sequence
    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        t_regs;
        t_password;
        t_nv_lock;
        t_unlock;
        t_vol_lreg;
        wrap_up;
    end
    // watchdog against a hung handshake
    initial begin
        #900000;
        error_cnt = error_cnt + 1;
        wrap_up;
    end
endmodule // test_fbp_ctrl

// ### verilog/fbp_bus_cycle.v
// one asynchronous flash bus cycle: write strobe or read strobe with sampling
`timescale 1ns/1ns
module fbp_bus_cycle #(
    parameter PHASE_CYC = 3
) (
    // clock and reset
    input wire clk,
    input wire sys_rst,
    // request
    input wire req,
    input wire rd,
    input wire [23:0] addr,
    input wire [15:0] wdata,
    output reg ack_r,
    output reg [15:0] rdata_r,
    // flash pins
    output reg [23:0] fl_addr_r,
    output reg [15:0] fl_dq_o_r,
    output reg fl_dq_oe_r,
    input wire [15:0] fl_dq_i,
    output reg fl_ce_n_r,
    output reg fl_oe_n_r,
    output reg fl_we_n_r
);
    localparam S_IDLE = 2'd0;
    localparam S_SETUP = 2'd1;
    localparam S_STROBE = 2'd2;
    localparam S_HOLD = 2'd3;
    reg [1:0] st_r;
    reg [7:0] cnt_r;
    reg rd_r;
    // three-stage sampler for the data pins, from outside this clock
    reg [15:0] dq_s1_r;
    reg [15:0] dq_s2_r;
    reg [15:0] dq_s3_r;
    always @(posedge clk) begin
        dq_s1_r <= fl_dq_i;
        dq_s2_r <= dq_s1_r;
        dq_s3_r <= dq_s2_r;
    end
    // cycle sequencer: setup, strobe low, release
    always @(posedge clk) begin
        if (sys_rst) begin
            st_r <= S_IDLE;
            cnt_r <= 8'h00;
            rd_r <= 1'b0;
            ack_r <= 1'b0;
            rdata_r <= 16'h0000;
            fl_addr_r <= 24'h000000;
            fl_dq_o_r <= 16'h0000;
            fl_dq_oe_r <= 1'b0;
            fl_ce_n_r <= 1'b1;
            fl_oe_n_r <= 1'b1;
            fl_we_n_r <= 1'b1;
        end else begin
            ack_r <= 1'b0;
            case (st_r)
                S_IDLE: begin
                    if (req) begin
                        fl_addr_r <= addr;
                        fl_dq_o_r <= wdata;
                        fl_dq_oe_r <= ~rd;
                        rd_r <= rd;
                        fl_ce_n_r <= 1'b0;
                        cnt_r <= PHASE_CYC[7:0];
                        st_r <= S_SETUP;
                    end
                end
                S_SETUP: begin
                    if (cnt_r <= 8'h01) begin
                        fl_oe_n_r <= ~rd_r;
                        fl_we_n_r <= rd_r;
                        cnt_r <= PHASE_CYC[7:0] + 8'h02; // extra for sampler delay
                        st_r <= S_STROBE;
                    end else begin
                        cnt_r <= cnt_r - 8'h01;
                    end
                end
                S_STROBE: begin
                    if (cnt_r <= 8'h01) begin
                        if (rd_r && dq_s2_r == dq_s3_r) begin
                            rdata_r <= dq_s3_r;
                        end
                        fl_oe_n_r <= 1'b1;
                        fl_we_n_r <= 1'b1;
                        cnt_r <= PHASE_CYC[7:0];
                        st_r <= S_HOLD;
                    end else begin
                        cnt_r <= cnt_r - 8'h01;
                    end
                end
                S_HOLD: begin
                    if (cnt_r <= 8'h01) begin
                        fl_ce_n_r <= 1'b1;
                        fl_dq_oe_r <= 1'b0;
                        ack_r <= 1'b1;
                        st_r <= S_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 8'h01;
                    end
                end
                default: st_r <= S_IDLE;
            endcase
        end
    end
endmodule // fbp_bus_cycle

// ### verilog/fbp_ctrl.v
// host controller issuing block protection command sequences to a parallel flash
`timescale 1ns/1ns
`include "fbp_regs.vh"
module fbp_ctrl #(
    parameter UNLOCK_GAP_CYC = `FBP_UNLOCK_GAP_CYC,
    parameter PHASE_CYC = `FBP_PHASE_CYC
) (
    // clock and reset
    input wire clk,
    input wire sys_rst,
    // axi4-lite write address and data
    input wire [11:0] s_awaddr,
    input wire s_awvalid,
    output reg s_awready_r,
    input wire [31:0] s_wdata,
    input wire [3:0] s_wstrb,
    input wire s_wvalid,
    output reg s_wready_r,
    // axi4-lite write response
    output reg [1:0] s_bresp_r,
    output reg s_bvalid_r,
    input wire s_bready,
    // axi4-lite read
    input wire [11:0] s_araddr,
    input wire s_arvalid,
    output reg s_arready_r,
    output reg [31:0] s_rdata_r,
    output reg [1:0] s_rresp_r,
    output reg s_rvalid_r,
    input wire s_rready,
    // flash pins
    output wire [23:0] fl_addr,
    output wire [15:0] fl_dq_o,
    output wire fl_dq_oe,
    input wire [15:0] fl_dq_i,
    output wire fl_ce_n,
    output wire fl_oe_n,
    output wire fl_we_n
);
    // software registers
    reg [3:0] op_r;
    reg x16_r;
    reg [23:0] addr_r;
    reg [15:0] wdata_r;
    reg [63:0] pw_r;
    reg busy_r;
    reg done_r;
    reg refused_r;
    reg [15:0] rdata_r;
    reg [31:0] gap_r;
    // sequencer state
    reg [4:0] step_r;
    reg [4:0] nsteps_r;
    reg cyc_req_r;
    reg cyc_rd_r;
    reg [23:0] cyc_addr_r;
    reg [15:0] cyc_wdata_r;
    wire cyc_ack;
    wire [15:0] cyc_rdata;
    reg [4:0] nsteps_nxt;
    reg [23:0] a_nxt;
    reg [15:0] d_nxt;
    reg rd_nxt;
    // axi holding
    reg aw_got_r;
    reg w_got_r;
    reg [11:0] aw_r;
    reg [31:0] w_r;
    reg [3:0] ws_r;

    fbp_bus_cycle #(.PHASE_CYC(PHASE_CYC)) u_cyc (
        .clk(clk),
        .sys_rst(sys_rst),
        .req(cyc_req_r),
        .rd(cyc_rd_r),
        .addr(cyc_addr_r),
        .wdata(cyc_wdata_r),
        .ack_r(cyc_ack),
        .rdata_r(cyc_rdata),
        .fl_addr_r(fl_addr),
        .fl_dq_o_r(fl_dq_o),
        .fl_dq_oe_r(fl_dq_oe),
        .fl_dq_i(fl_dq_i),
        .fl_ce_n_r(fl_ce_n),
        .fl_oe_n_r(fl_oe_n),
        .fl_we_n_r(fl_we_n)
    );

    // unlock cycle address for bus width
    function [23:0] unl_addr;
        input first;
        input x16;
        begin
            if (x16) begin
                unl_addr = first ? `FBP_A16_FIRST : `FBP_A16_SECOND;
            end else begin
                unl_addr = first ? `FBP_A8_FIRST : `FBP_A8_SECOND;
            end
        end
    endfunction

    // password portion for an index; bytes in x8, words in x16
    function [15:0] pw_portion;
        input [63:0] pw;
        input [2:0] idx;
        input x16;
        begin
            if (x16) begin
                pw_portion = pw[{idx[1:0], 4'h0} +: 16];
            end else begin
                pw_portion = {8'h00, pw[{idx, 3'h0} +: 8]};
            end
        end
    endfunction

    // cycles per operation
    always @* begin
        case (op_r)
            `FBP_OP_ENTER_LOCKREG, `FBP_OP_ENTER_PASSWORD, `FBP_OP_ENTER_NVPROT,
            `FBP_OP_ENTER_LOCKBIT, `FBP_OP_ENTER_VPROT: nsteps_nxt = 5'd3;
            `FBP_OP_EXIT, `FBP_OP_PROGRAM, `FBP_OP_CLEAR_ALL: nsteps_nxt = 5'd2;
            `FBP_OP_READ: nsteps_nxt = 5'd1;
            `FBP_OP_UNLOCK_PW: nsteps_nxt = x16_r ? 5'd7 : 5'd11;
            default: nsteps_nxt = 5'd0;
        endcase
    end

    // address, data and direction of the current step
    always @* begin
        a_nxt = 24'h000000;
        d_nxt = 16'h0000;
        rd_nxt = 1'b0;
        case (op_r)
            `FBP_OP_ENTER_LOCKREG, `FBP_OP_ENTER_PASSWORD, `FBP_OP_ENTER_NVPROT,
            `FBP_OP_ENTER_LOCKBIT, `FBP_OP_ENTER_VPROT: begin
                a_nxt = unl_addr(step_r != 5'd1, x16_r);
                if (step_r == 5'd0) begin
                    d_nxt = {8'h00, `FBP_D_UNLOCK1};
                end else if (step_r == 5'd1) begin
                    d_nxt = {8'h00, `FBP_D_UNLOCK2};
                end else if (op_r == `FBP_OP_ENTER_LOCKREG) begin
                    d_nxt = {8'h00, `FBP_D_LOCKREG};
                end else if (op_r == `FBP_OP_ENTER_PASSWORD) begin
                    d_nxt = {8'h00, `FBP_D_PASSWORD};
                end else if (op_r == `FBP_OP_ENTER_NVPROT) begin
                    d_nxt = {8'h00, `FBP_D_NVPROT};
                end else if (op_r == `FBP_OP_ENTER_LOCKBIT) begin
                    d_nxt = {8'h00, `FBP_D_LOCKBIT};
                end else begin
                    d_nxt = {8'h00, `FBP_D_VPROT};
                end
            end
            `FBP_OP_EXIT: begin
                d_nxt = {8'h00, (step_r == 5'd0) ? `FBP_D_EXIT1 : `FBP_D_EXIT2};
            end
            `FBP_OP_PROGRAM: begin
                // second cycle carries block or portion address and data; 00/01 from software
                if (step_r == 5'd0) begin
                    d_nxt = {8'h00, `FBP_D_PROGRAM};
                end else begin
                    a_nxt = addr_r;
                    d_nxt = wdata_r;
                end
            end
            `FBP_OP_READ: begin
                a_nxt = addr_r;
                rd_nxt = 1'b1;
            end
            `FBP_OP_CLEAR_ALL: begin
                d_nxt = {8'h00, (step_r == 5'd0) ? `FBP_D_CLR1 : `FBP_D_CLR2};
            end
            `FBP_OP_UNLOCK_PW: begin
                if (step_r == 5'd0) begin
                    d_nxt = {8'h00, `FBP_D_UNL1};
                end else if (step_r == 5'd1) begin
                    d_nxt = {8'h00, `FBP_D_UNL2};
                end else if (step_r == nsteps_r - 5'd1) begin
                    d_nxt = {8'h00, `FBP_D_UNL3};
                end else begin
                    a_nxt = {21'h000000, step_r[2:0] - 3'd2};
                    d_nxt = pw_portion(pw_r, step_r[2:0] - 3'd2, x16_r);
                end
            end
            default: begin
                a_nxt = 24'h000000;
            end
        endcase
    end

    // axi4-lite slave and command sequencer
    always @(posedge clk) begin
        if (sys_rst) begin
            s_awready_r <= 1'b0;
            s_wready_r <= 1'b0;
            s_bvalid_r <= 1'b0;
            s_bresp_r <= 2'b00;
            s_arready_r <= 1'b0;
            s_rvalid_r <= 1'b0;
            s_rresp_r <= 2'b00;
            s_rdata_r <= 32'h00000000;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            aw_r <= 12'h000;
            w_r <= 32'h00000000;
            ws_r <= 4'h0;
            op_r <= 4'h0;
            x16_r <= 1'b0;
            addr_r <= 24'h000000;
            wdata_r <= 16'h0000;
            pw_r <= 64'hFFFFFFFFFFFFFFFF;
            busy_r <= 1'b0;
            done_r <= 1'b0;
            refused_r <= 1'b0;
            rdata_r <= 16'h0000;
            gap_r <= 32'h00000000;
            step_r <= 5'd0;
            nsteps_r <= 5'd0;
            cyc_req_r <= 1'b0;
            cyc_rd_r <= 1'b0;
            cyc_addr_r <= 24'h000000;
            cyc_wdata_r <= 16'h0000;
        end else begin
            s_awready_r <= ~aw_got_r & s_awvalid & ~s_awready_r;
            s_wready_r <= ~w_got_r & s_wvalid & ~s_wready_r;
            s_arready_r <= ~s_rvalid_r & s_arvalid & ~s_arready_r;
            cyc_req_r <= 1'b0;
            if (gap_r != 32'h00000000) begin
                gap_r <= gap_r - 32'h00000001;
            end
            if (s_awvalid && s_awready_r) begin
                aw_got_r <= 1'b1;
                aw_r <= s_awaddr;
            end
            if (s_wvalid && s_wready_r) begin
                w_got_r <= 1'b1;
                w_r <= s_wdata;
                ws_r <= s_wstrb;
            end
            if (s_bvalid_r && s_bready) begin
                s_bvalid_r <= 1'b0;
            end
            // register write once both halves are held
            if (aw_got_r && w_got_r && !s_bvalid_r) begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                s_bvalid_r <= 1'b1;
                s_bresp_r <= 2'b00;
                case (aw_r)
                    `FBP_OFF_CTRL: begin
                        if (w_r[`FBP_CTRL_START_BIT] && ws_r[3]) begin
                            // unlock attempts inside the guard gap are refused locally
                            if (busy_r || (w_r[`FBP_CTRL_OP_MSB:`FBP_CTRL_OP_LSB]
                                    == `FBP_OP_UNLOCK_PW && gap_r != 32'h00000000)) begin
                                refused_r <= 1'b1;
                            end else begin
                                op_r <= w_r[`FBP_CTRL_OP_MSB:`FBP_CTRL_OP_LSB];
                                x16_r <= w_r[`FBP_CTRL_X16_BIT];
                                busy_r <= 1'b1;
                                done_r <= 1'b0;
                                step_r <= 5'd0;
                                nsteps_r <= 5'd0;
                            end
                        end
                    end
                    `FBP_OFF_ADDR: if (!busy_r) addr_r <= w_r[23:0];
                    `FBP_OFF_WDATA: if (!busy_r) wdata_r <= w_r[15:0];
                    `FBP_OFF_STATUS: begin
                        if (w_r[`FBP_ST_DONE_BIT]) done_r <= 1'b0;
                        if (w_r[`FBP_ST_REFUSED_BIT]) refused_r <= 1'b0;
                    end
                    `FBP_OFF_PWLO: if (!busy_r) pw_r[31:0] <= w_r;
                    `FBP_OFF_PWHI: if (!busy_r) pw_r[63:32] <= w_r;
                    default: s_bresp_r <= 2'b10;
                endcase
            end
            // register read
            if (s_rvalid_r && s_rready) begin
                s_rvalid_r <= 1'b0;
            end
            if (s_arvalid && s_arready_r) begin
                s_rvalid_r <= 1'b1;
                s_rresp_r <= 2'b00;
                case (s_araddr)
                    `FBP_OFF_CTRL: s_rdata_r <= {23'h000000, x16_r, 4'h0, op_r};
                    `FBP_OFF_ADDR: s_rdata_r <= {8'h00, addr_r};
                    `FBP_OFF_WDATA: s_rdata_r <= {16'h0000, wdata_r};
                    `FBP_OFF_STATUS: s_rdata_r <= {29'h00000000, refused_r, done_r, busy_r};
                    `FBP_OFF_RDATA: s_rdata_r <= {16'h0000, rdata_r};
                    `FBP_OFF_PWLO: s_rdata_r <= pw_r[31:0];
                    `FBP_OFF_PWHI: s_rdata_r <= pw_r[63:32];
                    default: begin
                        s_rdata_r <= 32'h00000000;
                        s_rresp_r <= 2'b10;
                    end
                endcase
            end
            // sequencer: launch a cycle, wait for its ack, step on
            if (busy_r) begin
                if (nsteps_r == 5'd0) begin
                    nsteps_r <= nsteps_nxt;
                    if (nsteps_nxt == 5'd0) begin
                        busy_r <= 1'b0;
                        refused_r <= 1'b1;
                    end
                end
                if (cyc_ack) begin
                    if (cyc_rd_r) begin
                        rdata_r <= cyc_rdata;
                    end
                    if (step_r + 5'd1 >= nsteps_r) begin
                        busy_r <= 1'b0;
                        done_r <= 1'b1;
                        if (op_r == `FBP_OP_UNLOCK_PW) begin
                            gap_r <= UNLOCK_GAP_CYC;
                        end
                    end else begin
                        step_r <= step_r + 5'd1;
                    end
                end
            end
            // register step data on the same edge as each request
            if (busy_r && nsteps_r != 5'd0 && !cyc_req_r && fl_ce_n && !cyc_ack) begin
                cyc_req_r <= 1'b1;
                cyc_rd_r <= rd_nxt;
                cyc_addr_r <= a_nxt;
                cyc_wdata_r <= d_nxt;
            end
        end
    end
endmodule // fbp_ctrl

// ### verilog/fbp_regs.vh
// register offsets, command codes and timing constants for the protection controller
`ifndef FBP_REGS_VH
`define FBP_REGS_VH
// controller register byte offsets
`define FBP_OFF_CTRL 12'h000
`define FBP_OFF_ADDR 12'h004
`define FBP_OFF_WDATA 12'h008
`define FBP_OFF_STATUS 12'h00C
`define FBP_OFF_RDATA 12'h010
`define FBP_OFF_PWLO 12'h014
`define FBP_OFF_PWHI 12'h018
// control fields
`define FBP_CTRL_OP_LSB 0
`define FBP_CTRL_OP_MSB 3
`define FBP_CTRL_X16_BIT 8
`define FBP_CTRL_START_BIT 31
// status fields
`define FBP_ST_BUSY_BIT 0
`define FBP_ST_DONE_BIT 1
`define FBP_ST_REFUSED_BIT 2
// operation codes
`define FBP_OP_ENTER_LOCKREG 4'h0
`define FBP_OP_ENTER_PASSWORD 4'h1
`define FBP_OP_ENTER_NVPROT 4'h2
`define FBP_OP_ENTER_LOCKBIT 4'h3
`define FBP_OP_ENTER_VPROT 4'h4
`define FBP_OP_EXIT 4'h5
`define FBP_OP_PROGRAM 4'h6
`define FBP_OP_READ 4'h7
`define FBP_OP_CLEAR_ALL 4'h8
`define FBP_OP_UNLOCK_PW 4'h9
// flash command data codes
`define FBP_D_UNLOCK1 8'hAA
`define FBP_D_UNLOCK2 8'h55
`define FBP_D_LOCKREG 8'h40
`define FBP_D_PASSWORD 8'h60
`define FBP_D_NVPROT 8'hC0
`define FBP_D_LOCKBIT 8'h50
`define FBP_D_VPROT 8'hE0
`define FBP_D_PROGRAM 8'hA0
`define FBP_D_EXIT1 8'h90
`define FBP_D_EXIT2 8'h00
`define FBP_D_CLR1 8'h80
`define FBP_D_CLR2 8'h30
`define FBP_D_UNL1 8'h25
`define FBP_D_UNL2 8'h03
`define FBP_D_UNL3 8'h29
`define FBP_D_PROTECTED 8'h00
`define FBP_D_UNPROTECTED 8'h01
// unlock cycle addresses per bus width
`define FBP_A8_FIRST 24'h000AAA
`define FBP_A8_SECOND 24'h000555
`define FBP_A16_FIRST 24'h000555
`define FBP_A16_SECOND 24'h0002AA
// timing
`define FBP_CLK_MHZ 100
`define FBP_UNLOCK_GAP_US 6
`define FBP_UNLOCK_GAP_CYC (`FBP_UNLOCK_GAP_US * `FBP_CLK_MHZ)
`define FBP_PHASE_NS 30
`define FBP_PHASE_CYC ((`FBP_PHASE_NS * `FBP_CLK_MHZ + 999) / 1000)
`endif
